// ---- rtl/mldc_defs.svh ----
`ifndef MLDC_DEFS_SVH
`define MLDC_DEFS_SVH

// ************************************************
// serial word layout
// ************************************************
`define MLDC_WORD_BITS       24
`define MLDC_AUX_SEL_BIT     23
`define MLDC_LOCK_SEL_BIT    22
`define MLDC_DET_TOP_BIT     21
`define MLDC_DET_LOW_MSB     20
`define MLDC_DET_LOW_LSB     19
`define MLDC_CUR_SEL_BIT     18
`define MLDC_DIV_MSB         17
`define MLDC_DIV_LSB         0
`define MLDC_WORD_RESET      24'h000000

// ************************************************
// ratios and windows
// ************************************************
`define MLDC_AUX_HALF_10     5'h14
`define MLDC_AUX_HALF_12P5   5'h19
`define MLDC_AUX_HALF_8      5'h10
`define MLDC_LOCK_WIN_NARROW 8'h20
`define MLDC_LOCK_WIN_WIDE   8'h80
`define MLDC_ADAPT_BASE      8'h10

`endif

// ---- rtl/mldc_pkg.sv ----
package mldc_pkg;
    typedef struct packed {
        logic        aux_ratio_select;
        logic        lock_window_select;
        logic        detector_program_top;
        logic [1:0]  detector_program_low;
        logic        current_ratio_select;
        logic [17:0] main_divide;
    } mldc_word_t;

    typedef enum logic [1:0] {
        MLDC_IDLE    = 2'b01,
        MLDC_PENDING = 2'b10
    } mldc_load_t;
endpackage

// ---- rtl/mldc_top.sv ----
`timescale 1ns/1ps
`include "mldc_defs.svh"

// Summary of operation
// R1: mode low: auxiliary ratio select chooses auxiliary output divide ratio.
// R2: host writes auxiliary ratio select as one when mode is high.
// R3: select zero: divide oscillator by 10, or 12.5 if low reference bits nonzero.
// R4: select one: divide oscillator by 8, or 10 if low reference bits nonzero.
// R5: lock window is 32 oscillator periods, or 128 when select is one.
// R6: top program bit zero: middle enables high output, lowest enables low output.
// R7: top bit one: high output for 16..128 reference pulses, then low output.
// R8: current ratio 4:1, or 8:1 by halving low-side current when bit set.
// R9: main divide field is plain unsigned binary divide value.
// R10: host writes main divide only within 992 to 262143.
// R11: after reload on reference pulse, feedback and reference count together.
// R12: adapt timer restarts from zero when a new word is latched.
// R13: host shifts 24 bits msb first; new fields apply only after full word.
module mldc_top
    import mldc_pkg::*;
#(
    parameter int DIV_W = 18
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ser_clk,
    input  wire logic        ser_data,
    input  wire logic        ser_enable_n,
    input  wire logic        mode_pin,
    input  wire logic        osc_in,
    input  wire logic        vco_in,
    input  wire logic        reference_divider_pulse,
    input  wire logic [1:0]  sec_ref_low,
    output logic             aux_reference_output,
    output logic             main_detector_high_current_en,
    output logic             main_detector_low_current_en,
    output logic             low_current_half,
    output logic [7:0]       lock_window_width,
    output logic             main_feedback_pulse,
    output logic             word_applied
);

    // ************************************************
    // serial side, on the link clock
    // ************************************************
    logic [22:0] shift_reg;
    logic [4:0]  bit_count;
    logic [23:0] snap_word;
    logic        snap_toggle;
    wire         frame_idle = ~rst_n | ser_enable_n;

    // R13: count clears between frames so a short frame never snaps
    always_ff @(posedge ser_clk or posedge frame_idle) begin
        if (frame_idle) begin
            bit_count <= 5'h00;
        end else if (bit_count != 5'h18) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    always_ff @(posedge ser_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 23'h000000;
        end else begin
            shift_reg <= {shift_reg[21:0], ser_data};
        end
    end

    // R13: msb first, 24th bit completes the word; later bits are ignored
    wire snap_now = ~ser_enable_n & (bit_count == 5'h17);

    always_ff @(posedge ser_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_word   <= `MLDC_WORD_RESET;
            snap_toggle <= 1'b0;
        end else if (snap_now) begin
            snap_word   <= {shift_reg, ser_data};
            snap_toggle <= ~snap_toggle;
        end
    end

    // ************************************************
    // synchronisers into mclk
    // ************************************************
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    wire  [5:0] raw_in = {snap_toggle, ser_enable_n, osc_in, vco_in,
                          reference_divider_pulse, mode_pin};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 6'h10;
            sync_b <= 6'h10;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic [5:0] sync_d;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_d <= 6'h10;
        end else begin
            sync_d <= sync_b;
        end
    end

    wire toggle_seen = sync_b[5] ^ sync_d[5];
    wire enable_hi   = sync_b[4];
    wire osc_edge    = sync_b[3] ^ sync_d[3];
    wire vco_rise    = sync_b[2] & ~sync_d[2];
    wire ref_rise    = sync_b[1] & ~sync_d[1];
    wire mode_hi     = sync_b[0];

    // ************************************************
    // word load
    // ************************************************
    mldc_load_t  load_state;
    mldc_word_t  main_loop_divider_word;
    wire         apply_now = (load_state == MLDC_PENDING) & enable_hi;

    // R13: snapped word is stable until the next frame's 24th bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            load_state <= MLDC_IDLE;
        end else begin
            case (load_state)
                MLDC_IDLE: begin
                    if (toggle_seen) begin
                        load_state <= MLDC_PENDING;
                    end
                end
                MLDC_PENDING: begin
                    if (apply_now) begin
                        load_state <= MLDC_IDLE;
                    end
                end
                default: begin
                    load_state <= MLDC_IDLE;
                end
            endcase
        end
    end

    // R13: fields change only at end of a complete transfer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_loop_divider_word <= mldc_word_t'(`MLDC_WORD_RESET);
            word_applied           <= 1'b0;
        end else begin
            word_applied <= apply_now;
            if (apply_now) begin
                main_loop_divider_word <= mldc_word_t'(snap_word);
            end
        end
    end

    // ************************************************
    // auxiliary divider, counted in oscillator half periods
    // ************************************************
    logic [4:0] aux_count;
    wire        ref_low_any = |sec_ref_low;
    // R3: ratio 10 or 12.5 with select at zero
    // R4: ratio 8 or 10 with select at one
    wire  [4:0] aux_half = main_loop_divider_word.aux_ratio_select ?
                           (ref_low_any ? `MLDC_AUX_HALF_10 : `MLDC_AUX_HALF_8) :
                           (ref_low_any ? `MLDC_AUX_HALF_12P5 : `MLDC_AUX_HALF_10);
    wire        aux_wrap = (aux_count >= aux_half - 5'h01);

    // R1: divider only runs while mode pin is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aux_count            <= 5'h00;
            aux_reference_output <= 1'b0;
        end else if (mode_hi) begin
            aux_count            <= 5'h00;
            aux_reference_output <= 1'b0;
        end else if (osc_edge) begin
            aux_count            <= aux_wrap ? 5'h00 : aux_count + 5'h01;
            aux_reference_output <= (aux_wrap ? 5'h00 : aux_count + 5'h01) < (aux_half >> 1);
        end
    end

    // ************************************************
    // detector program, adapt timer, window, current ratio
    // ************************************************
    logic [7:0] adapt_count;
    wire  [7:0] adapt_limit = `MLDC_ADAPT_BASE << main_loop_divider_word.detector_program_low;
    wire        adapt_done  = (adapt_count >= adapt_limit);

    // R12: timer restarts on every newly latched word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            adapt_count <= 8'h00;
        end else if (apply_now) begin
            adapt_count <= 8'h00;
        end else if (ref_rise & ~adapt_done) begin
            adapt_count <= adapt_count + 8'h01;
        end
    end

    wire next_hi_en = main_loop_divider_word.detector_program_top ?
                      ~adapt_done : main_loop_divider_word.detector_program_low[1];
    wire next_lo_en = main_loop_divider_word.detector_program_top ?
                      adapt_done : main_loop_divider_word.detector_program_low[0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_detector_high_current_en <= 1'b0;
            main_detector_low_current_en  <= 1'b0;
            low_current_half              <= 1'b0;
            lock_window_width             <= `MLDC_LOCK_WIN_NARROW;
        end else begin
            // R6: static enables
            // R7: adapt switch from high to low
            main_detector_high_current_en <= next_hi_en;
            main_detector_low_current_en  <= next_lo_en;
            // R8: halve low side current
            low_current_half              <= main_loop_divider_word.current_ratio_select;
            // R5: lock window width
            lock_window_width <= main_loop_divider_word.lock_window_select ?
                                 `MLDC_LOCK_WIN_WIDE : `MLDC_LOCK_WIN_NARROW;
        end
    end

    // ************************************************
    // main feedback divider
    // ************************************************
    logic [DIV_W-1:0] main_count;
    wire  [DIV_W-1:0] main_ratio = DIV_W'(main_loop_divider_word.main_divide);

    // R9: plain binary divide value
    // R11: reload on reference pulse, then count down on each vco rising edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            main_count          <= '0;
            main_feedback_pulse <= 1'b0;
        end else if (ref_rise) begin
            main_count          <= main_ratio;
            main_feedback_pulse <= 1'b0;
        end else if (vco_rise) begin
            main_count          <= (main_count <= DIV_W'(1)) ? main_ratio
                                                             : main_count - DIV_W'(1);
            main_feedback_pulse <= (main_count == DIV_W'(1));
        end else begin
            main_feedback_pulse <= 1'b0;
        end
    end

endmodule

// ---- tb/mldc_assertions.sv ----
`timescale 1ns/1ps
// ************************************************
// port checker
// ************************************************
module mldc_assertions (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       ser_enable_n,
    input wire logic       mode_pin,
    input wire logic       aux_reference_output,
    input wire logic       main_detector_high_current_en,
    input wire logic       main_detector_low_current_en,
    input wire logic       low_current_half,
    input wire logic [7:0] lock_window_width,
    input wire logic       main_feedback_pulse,
    input wire logic       word_applied
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_aux_mode_off: assert property (mode_pin [*4] |-> !aux_reference_output)
        else $error("aux output active with mode high");
    a_lock_width_val: assert property (lock_window_width == 8'h20 || lock_window_width == 8'h80)
        else $error("lock window width illegal");
    a_lock_width_apply: assert property ($changed(lock_window_width) |-> $past(word_applied))
        else $error("lock window changed without word");
    a_half_apply: assert property ($changed(low_current_half) |-> $past(word_applied))
        else $error("current ratio changed without word");
    a_high_on_apply: assert property ($rose(main_detector_high_current_en) |-> $past(word_applied))
        else $error("high output enabled without word");
    a_low_handover: assert property ($rose(main_detector_low_current_en)
        |-> $past(word_applied) || $fell(main_detector_high_current_en))
        else $error("low output enabled out of turn");
    a_apply_after_frame: assert property (word_applied |-> $past(ser_enable_n, 3))
        else $error("word applied inside a frame");
    a_apply_pulse: assert property (word_applied |=> !word_applied)
        else $error("word applied pulse too long");
    a_feedback_pulse: assert property (main_feedback_pulse |=> !main_feedback_pulse)
        else $error("feedback pulse too long");
endmodule

bind mldc_top mldc_assertions chk (.mclk, .rst_n, .ser_enable_n, .mode_pin,
    .aux_reference_output, .main_detector_high_current_en, .main_detector_low_current_en,
    .low_current_half, .lock_window_width, .main_feedback_pulse, .word_applied);

// ---- tb/mldc_host.sv ----
`timescale 1ns/1ps
// ************************************************
// serial host model, 32 ns link clock
// ************************************************
module mldc_host (
    output logic ser_clk,
    output logic ser_data,
    output logic ser_enable_n
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_enable_n = 1'b1;
    end
    task automatic send(input logic [23:0] w, input int n);
        #7.3;
        ser_enable_n = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            #8 ser_data = w[i];
            #8 ser_clk = 1'b1;
            #16 ser_clk = 1'b0;
        end
        // clock stands still, data no longer valid after the frame
        #24 ser_enable_n = 1'b1;
        ser_data = ~ser_data;
        #40;
    endtask
endmodule

// ---- tb/mldc_top_tb.sv ----
`timescale 1ns/1ps
module mldc_top_tb import mldc_pkg::*; ;
    logic       mclk = 1'b0, rst_n = 1'b0, mode_pin = 1'b0, refp = 1'b0, sel = 1'b0;
    logic       osc_in = 1'b0, vco_in = 1'b0, mon_d = 1'b0;
    logic [1:0] sec_ref_low = 2'h0;
    logic [2:0] ph = 3'h0;
    wire  logic ser_clk, ser_data, ser_enable_n, aux_o, hi, lo, half, fb, applied;
    wire  logic [7:0] lww;
    wire  logic mon = sel ? fb : aux_o;
    int         err_total = 0, checked = 0, napp = 0, n, b;
    int         halfs [4] = '{20, 25, 16, 20};
    mldc_word_t w;

    always #2.5 mclk = ~mclk;
    // osc and vco share one 8-cycle input clock
    always @(posedge mclk) begin
        ph <= ph + 3'h1;
        osc_in <= #1 ph[2];
        vco_in <= #1 ph[2];
        mon_d <= mon;
        napp <= napp + (applied === 1'b1);
    end

    mldc_host host (.ser_clk(ser_clk), .ser_data(ser_data), .ser_enable_n(ser_enable_n));
    mldc_top dut (.mclk(mclk), .rst_n(rst_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_enable_n(ser_enable_n), .mode_pin(mode_pin), .osc_in(osc_in), .vco_in(vco_in),
        .reference_divider_pulse(refp), .sec_ref_low(sec_ref_low),
        .aux_reference_output(aux_o), .main_detector_high_current_en(hi),
        .main_detector_low_current_en(lo), .low_current_half(half),
        .lock_window_width(lww), .main_feedback_pulse(fb), .word_applied(applied));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input int k);
        b = napp;
        host.send(w, k);
        cyc(2);
        chk("applied", napp - b, k == 24);
    endtask
    task automatic rise(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (!(mon === 1'b1 && mon_d === 1'b0) && k < 20000);
        #1;
    endtask
    task automatic refs(input int k);
        repeat (k) begin
            refp = 1'b1;
            cyc(4);
            refp = 1'b0;
            cyc(4);
        end
    endtask

    initial begin
        // about three times the expected run, well under the cycle budget
        #300000;
        err_total++;
        report_and_stop;
    end

    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(3);
        chk("reset width", lww, 32'h20);
        chk("reset enables", {hi, lo}, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            sec_ref_low = i[0] ? 2'h2 : 2'h0;
            w = '{i[1], i[0], 1'b0, i[1:0], i[1], 18'd1000};
            wr(24);
            chk("enables", {hi, lo}, i);
            chk("width", lww, i[0] ? 32'h80 : 32'h20);
            chk("half", half, i[1]);
            rise(n);
            rise(n);
            chk("aux period", n, halfs[i] * 4);
        end
        $display("static fields done");
        w = '{1'b0, 1'b1, 1'b0, 2'h3, 1'b1, 18'd992};
        wr(24);
        w.main_divide = 18'd2000;
        wr(23);
        refs(1);
        sel = 1'b1;
        rise(n);
        rise(n);
        chk("feedback period", n, 992 * 8);
        sel = 1'b0;
        $display("main divide done");
        mode_pin = 1'b1;
        w.aux_ratio_select = 1'b1;
        wr(24);
        cyc(40);
        chk("aux off", aux_o, 1'b0);
        mode_pin = 1'b0;
        $display("mode pin done");
        w = '{1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 18'd1000};
        wr(24);
        refs(10);
        for (int k = 0; k < 4; k++) begin
            w.detector_program_low = k[1:0];
            wr(24);
            refs((16 << k) - 1);
            chk("adapt hold", {hi, lo}, 32'h2);
            refs(1);
            chk("adapt swap", {hi, lo}, 32'h1);
        end
        $display("adapt timer done");
        report_and_stop;
    end
endmodule
